// >>> rtl/dppg_top.sv
// Purpose: Parity check and generation for both 36-bit ports of a mailbox buffer
// Assumes: Single clock ref_clk; both port clocks are the same domain here
// Notes:   Fault flags are combinational; outputs registered per port
`timescale 1ns/100ps
`include "dppg_defs.svh"
module dppg_top (
  input  wire logic                    ref_clk,                  // 40 MHz clock
  input  wire logic                    rstn,                     // Async reset, low
  input  wire logic                    odd_sense,                // High: odd parity
  input  wire logic                    port_a_chip_select_n,     // Port A select, low
  input  wire logic                    port_a_gate_active,       // Port A enable
  input  wire logic                    port_a_write_not_read,    // Port A write high
  input  wire logic                    port_a_mail_choose,       // Port A mailbox path
  input  wire logic                    port_a_parity_gen_select, // Port A generate
  input  wire logic [`DPPG_WORD_W-1:0] port_a_bus_in,            // Port A pins in
  output logic      [`DPPG_WORD_W-1:0] port_a_bus_out,           // Port A data out
  output logic                         port_a_bus_oe,            // Port A drive
  output logic                         port_a_parity_fault_n,    // Port A fault, low
  input  wire logic                    port_b_chip_select_n,     // Port B select, low
  input  wire logic                    port_b_gate_active,       // Port B enable
  input  wire logic                    port_b_write_not_read,    // Port B write high
  input  wire logic                    port_b_mail_choose,       // Port B mailbox path
  input  wire logic                    port_b_parity_gen_select, // Port B generate
  input  wire logic [`DPPG_WORD_W-1:0] port_b_bus_in,            // Port B pins in
  output logic      [`DPPG_WORD_W-1:0] port_b_bus_out,           // Port B data out
  output logic                         port_b_bus_oe,            // Port B drive
  output logic                         port_b_parity_fault_n,    // Port B fault, low
  input  wire logic                    buf_read_load,            // Load buffer word
  input  wire logic [`DPPG_WORD_W-1:0] buf_read_word,            // Word from storage
  output logic      [`DPPG_WORD_W-1:0] buf_write_word,           // Word to storage
  output logic                         buf_write_strobe          // Port A buffer write
);
  dppg_pkg::dppg_word_t first_mailbox;
  dppg_pkg::dppg_word_t second_mailbox;
  dppg_pkg::dppg_word_t buf_out_reg;
  dppg_pkg::dppg_word_t next_buf_out;
  dppg_pkg::dppg_word_t a_gen_word;
  dppg_pkg::dppg_word_t b_gen_word;
  dppg_pkg::dppg_word_t buf_gen_word;
  dppg_pkg::dppg_path_t a_path;
  dppg_pkg::dppg_path_t b_path;
  logic                 a_mail_read;
  logic                 b_mail_read;
  logic                 a_read;
  logic                 b_read;
  logic                 a_mail_write;
  logic                 b_mail_write;

  dppg_tree_if ta ();
  dppg_tree_if tb ();
  dppg_tree_if tf ();

  dppg_tree u_tree_a (.t(ta));
  dppg_tree u_tree_b (.t(tb));
  // Buffer path has its own trees so mailbox checks on port B stay live
  dppg_tree u_tree_f (.t(tf));

  assign a_read = ~port_a_chip_select_n & port_a_gate_active & ~port_a_write_not_read;
  assign b_read = ~port_b_chip_select_n & port_b_gate_active & ~port_b_write_not_read;
  assign a_mail_read = a_read & port_a_mail_choose & port_a_parity_gen_select;
  assign b_mail_read = b_read & port_b_mail_choose & port_b_parity_gen_select;
  assign a_mail_write = ~port_a_chip_select_n & port_a_gate_active & port_a_write_not_read
                        & port_a_mail_choose;
  assign b_mail_write = ~port_b_chip_select_n & port_b_gate_active & port_b_write_not_read
                        & port_b_mail_choose;

  assign a_path = a_mail_read ? dppg_pkg::DPPG_PATH_GEN : dppg_pkg::DPPG_PATH_CHECK;
  assign b_path = b_mail_read ? dppg_pkg::DPPG_PATH_GEN : dppg_pkg::DPPG_PATH_CHECK;

  // Shared trees: mailbox data replaces pin data during a generating read
  assign ta.word = (a_path == dppg_pkg::DPPG_PATH_GEN) ? second_mailbox : port_a_bus_in;
  assign tb.word = (b_path == dppg_pkg::DPPG_PATH_GEN) ? first_mailbox : port_b_bus_in;
  assign ta.odd_sense = odd_sense;
  assign tb.odd_sense = odd_sense;
  assign tf.word = buf_read_word;
  assign tf.odd_sense = odd_sense;

  // Flags are pure combinational functions of current inputs
  assign port_a_parity_fault_n = a_mail_read ? 1'b1 : ~(|ta.lane_bad);
  assign port_b_parity_fault_n = b_mail_read ? 1'b1 : ~(|tb.lane_bad);

  function automatic dppg_pkg::dppg_word_t put_parity(input dppg_pkg::dppg_word_t w,
                                                       input logic [`DPPG_LANES-1:0] p);
    dppg_pkg::dppg_word_t r;
    r = w;
    for (int i = 0; i < `DPPG_LANES; i++) begin
      r[i*`DPPG_LANE_W + `DPPG_PAR_BIT] = p[i];
    end
    return r;
  endfunction : put_parity

  assign a_gen_word = put_parity(second_mailbox, ta.gen_bit);
  assign b_gen_word = put_parity(first_mailbox, tb.gen_bit);
  assign buf_gen_word = put_parity(buf_read_word, tf.gen_bit);

  // Parity inserted before the output register, so selects must be stable at the load edge
  assign next_buf_out = port_b_parity_gen_select ? buf_gen_word : buf_read_word;

  // Writes take raw pin levels; parity generation touches only read paths
  assign buf_write_word = port_a_bus_in;
  assign buf_write_strobe = ~port_a_chip_select_n & port_a_gate_active &
                            port_a_write_not_read & ~port_a_mail_choose;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      first_mailbox <= '0;
    end else if (a_mail_write) begin
      first_mailbox <= port_a_bus_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      second_mailbox <= '0;
    end else if (b_mail_write) begin
      second_mailbox <= port_b_bus_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      buf_out_reg <= '0;
    end else if (buf_read_load) begin
      buf_out_reg <= next_buf_out;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_a_bus_out <= '0;
      port_a_bus_oe  <= 1'b0;
    end else begin
      port_a_bus_oe  <= a_read;
      port_a_bus_out <= a_mail_read ? a_gen_word : second_mailbox;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_b_bus_out <= '0;
      port_b_bus_oe  <= 1'b0;
    end else begin
      port_b_bus_oe <= b_read;
      if (port_b_mail_choose) begin
        port_b_bus_out <= b_mail_read ? b_gen_word : first_mailbox;
      end else begin
        port_b_bus_out <= buf_out_reg;
      end
    end
  end
endmodule : dppg_top

// >>> rtl/dppg_defs.svh
// Purpose: Constants for the dual port parity check and generate block
// Assumes: 36-bit ports split into four 9-bit lanes
// Notes:   Definitions only
`ifndef DPPG_DEFS_SVH
`define DPPG_DEFS_SVH
`define DPPG_WORD_W   36
`define DPPG_LANE_W   9
`define DPPG_LANES    4
`define DPPG_DATA_W   8
`define DPPG_PAR_BIT  8
`endif

// >>> rtl/dppg_pkg.sv
// Purpose: Types for the dual port parity block
// Assumes: dppg_defs.svh supplies widths
// Notes:   Word type and tree path select enum only
`include "dppg_defs.svh"
package dppg_pkg;
  typedef logic [`DPPG_WORD_W-1:0] dppg_word_t;
  typedef enum logic [1:0] {
    DPPG_PATH_CHECK = 2'h1,
    DPPG_PATH_GEN   = 2'h2
  } dppg_path_t;
endpackage : dppg_pkg

// >>> rtl/dppg_tree_if.sv
// Purpose: Carries one port's shared parity tree inputs and results
// Assumes: Combinational tree
// Notes:   Tree results are per-lane generated bits and lane fault flags
`timescale 1ns/100ps
`include "dppg_defs.svh"
interface dppg_tree_if;
  logic [`DPPG_WORD_W-1:0] word;      // Word fed to the trees
  logic                    odd_sense; // High selects odd parity
  logic [`DPPG_LANES-1:0]  gen_bit;   // Generated parity per lane
  logic [`DPPG_LANES-1:0]  lane_bad;  // Lane failed check
  modport user (output word, output odd_sense, input gen_bit, input lane_bad);
  modport tree (input word, input odd_sense, output gen_bit, output lane_bad);
endinterface : dppg_tree_if

// >>> rtl/dppg_tree.sv
// Purpose: Four byte-lane parity trees, used for checking and generating
// Assumes: Word mapped as lanes of 9 bits, msb of lane is parity
// Notes:   Purely combinational
`timescale 1ns/100ps
`include "dppg_defs.svh"
module dppg_tree (
  dppg_tree_if.tree t // Shared tree port
);
  genvar g;
  generate
    for (g = 0; g < `DPPG_LANES; g = g + 1) begin : g_lane
      logic [`DPPG_LANE_W-1:0] lane;
      logic                    ones8;
      logic                    zeros9;
      assign lane = t.word[g*`DPPG_LANE_W +: `DPPG_LANE_W];
      assign ones8 = ^lane[`DPPG_DATA_W-1:0];
      // Odd count of low bits in 9 bits equals even count of ones
      assign zeros9 = ~(^lane);
      assign t.lane_bad[g] = t.odd_sense ? zeros9 : ~zeros9;
      assign t.gen_bit[g] = t.odd_sense ? ~ones8 : ones8;
    end
  endgenerate
endmodule : dppg_tree

// >>> dv/dppg_top_sva.sv
// Purpose: Port assertions for dppg_top
// Assumes: One clock, async active-low reset
// Notes:   Fault flags sampled at the clock edge only
`timescale 1ns/100ps
`include "dppg_defs.svh"
module dppg_top_sva (
  input wire logic ref_clk, rstn, odd_sense, port_a_bus_oe, port_b_bus_oe,
  input wire logic port_a_chip_select_n, port_a_gate_active, port_a_write_not_read,
  input wire logic port_a_mail_choose, port_a_parity_gen_select, port_a_parity_fault_n,
  input wire logic port_b_chip_select_n, port_b_gate_active, port_b_write_not_read,
  input wire logic port_b_mail_choose, port_b_parity_gen_select, port_b_parity_fault_n,
  input wire logic [`DPPG_WORD_W-1:0] port_a_bus_in, port_a_bus_out, buf_write_word,
  input wire logic [`DPPG_WORD_W-1:0] port_b_bus_in, port_b_bus_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire rd_a = !port_a_chip_select_n && port_a_gate_active && !port_a_write_not_read;
  wire rd_b = !port_b_chip_select_n && port_b_gate_active && !port_b_write_not_read;
  wire mg_a = rd_a && port_a_mail_choose && port_a_parity_gen_select;
  wire mg_b = rd_b && port_b_mail_choose && port_b_parity_gen_select;
  function automatic logic bad(input logic [35:0] w, input logic odd);
    bad = 1'b0;
    for (int k = 0; k < 4; k++) bad |= (^w[9*k+:9]) != odd;
  endfunction : bad
  chk_fault_a_lane: assert property (!mg_a |-> port_a_parity_fault_n == !bad(port_a_bus_in, odd_sense))
    else $error("port A fault flag wrong");
  chk_fault_b_lane: assert property (!mg_b |-> port_b_parity_fault_n == !bad(port_b_bus_in, odd_sense))
    else $error("port B fault flag wrong");
  chk_force_a_high: assert property (mg_a |-> port_a_parity_fault_n)
    else $error("port A flag not held high");
  chk_force_b_high: assert property (mg_b |-> port_b_parity_fault_n)
    else $error("port B flag not held high");
  chk_write_raw: assert property (buf_write_word == port_a_bus_in)
    else $error("write word altered");
  chk_gen_a_out: assert property (mg_a |=> !bad(port_a_bus_out, $past(odd_sense)))
    else $error("port A generated parity wrong");
  chk_gen_b_mail: assert property (mg_b |=> !bad(port_b_bus_out, $past(odd_sense)))
    else $error("port B generated parity wrong");
  chk_oe_read_b: assert property (rd_b |=> port_b_bus_oe && $past(rd_b))
    else $error("port B not driven on read");
  cover property (mg_a);
  cover property (mg_b);
  cover property (!port_a_parity_fault_n);
endmodule : dppg_top_sva
bind dppg_top dppg_top_sva u_dppg_top_sva (.*);

// >>> dv/dppg_store_model.sv
// Purpose: Storage side feeding buffer words
// Assumes: Word read advances on each load
// Notes:   Word pattern is simple so the bench can predict it
`timescale 1ns/100ps
module dppg_store_model (
  input  wire logic        ref_clk, // Clock
  input  wire logic        rstn,    // Reset, low
  input  wire logic        load,    // Word taken
  output logic      [35:0] word     // Next stored word
);
  logic [5:0] ptr;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) ptr <= 6'h00;
    else if (load) ptr <= ptr + 6'h01;
  end
  assign word = 36'hF0F0F0F0F ^ {30'h0, ptr};
endmodule : dppg_store_model

// >>> dv/tb_dppg_top.sv
// Purpose: Self-checking bench for dppg_top
// Assumes: Inputs change on the falling edge
// Notes:   Expected parity computed locally
`timescale 1ns/100ps
`include "dppg_defs.svh"
module tb_dppg_top;
  logic ref_clk = 1'b0, rstn = 1'b0, odd_sense = 1'b0, buf_read_load = 1'b0;
  logic port_a_chip_select_n = 1'b1, port_a_gate_active = 1'b0, port_a_write_not_read = 1'b0;
  logic port_a_mail_choose = 1'b0, port_a_parity_gen_select = 1'b0;
  logic port_b_chip_select_n = 1'b1, port_b_gate_active = 1'b0, port_b_write_not_read = 1'b0;
  logic port_b_mail_choose = 1'b0, port_b_parity_gen_select = 1'b0;
  logic [35:0] port_a_bus_in = 36'h0, port_b_bus_in = 36'h0, buf_read_word;
  logic [35:0] port_a_bus_out, port_b_bus_out, buf_write_word;
  logic port_a_bus_oe, port_b_bus_oe, port_a_parity_fault_n, port_b_parity_fault_n;
  logic buf_write_strobe;
  int num_errors = 0, checks_done = 0, cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  dppg_top u_dppg_top (.*);
  dppg_store_model u_dppg_store_model (.ref_clk(ref_clk), .rstn(rstn),
    .load(buf_read_load), .word(buf_read_word));
  function automatic logic [35:0] gen(input logic [35:0] w, input logic odd);
    for (int k = 0; k < 4; k++) w[9*k+8] = ^w[9*k+:8] ^ odd;
    return w;
  endfunction : gen
  task automatic cmp_word(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_word({35'h0, got}, {35'h0, exp});
  endtask : cmp_flag
  task automatic ctl(input logic [4:0] a, input logic [4:0] b);
    {port_a_chip_select_n, port_a_gate_active, port_a_write_not_read,
     port_a_mail_choose, port_a_parity_gen_select} = a;
    {port_b_chip_select_n, port_b_gate_active, port_b_write_not_read,
     port_b_mail_choose, port_b_parity_gen_select} = b;
  endtask : ctl
  task automatic t_check();
    logic [35:0] w;
    for (int s = 0; s < 2; s++)
      for (int b = 0; b < 37; b++) begin
        @(negedge ref_clk);
        w = gen(36'h123456789, s[0]);
        if (b < 36) w[b] = ~w[b];
        odd_sense = s[0];
        port_a_bus_in = w;
        port_b_bus_in = w;
        #1;
        cmp_flag(port_a_parity_fault_n, b == 36);
        cmp_flag(port_b_parity_fault_n, b == 36);
      end
  endtask : t_check
  task automatic t_mail();
    logic [35:0] v = 36'hFFF000ABC, u = 36'h00F0F1234;
    @(negedge ref_clk);
    odd_sense = 1'b1;
    port_a_bus_in = v;
    port_b_bus_in = u;
    ctl(5'h0E, 5'h0E);
    #1;
    cmp_word(buf_write_word, v);
    cmp_flag(buf_write_strobe, 1'b0);
    @(negedge ref_clk);
    port_a_bus_in = 36'h0;
    port_b_bus_in = 36'h0;
    ctl(5'h0B, 5'h0B);
    #1;
    cmp_flag(port_a_parity_fault_n, 1'b1);
    cmp_flag(port_b_parity_fault_n, 1'b1);
    @(negedge ref_clk);
    cmp_word(port_b_bus_out, gen(v, 1'b1));
    cmp_word(port_a_bus_out, gen(u, 1'b1));
    cmp_flag(port_a_bus_oe, 1'b1);
    cmp_flag(port_b_bus_oe, 1'b1);
    ctl(5'h0A, 5'h0A);
    @(negedge ref_clk);
    cmp_word(port_b_bus_out, v);
    cmp_word(port_a_bus_out, u);
    odd_sense = 1'b0;
    ctl(5'h0B, 5'h0B);
    @(negedge ref_clk);
    cmp_word(port_b_bus_out, gen(v, 1'b0));
    cmp_word(port_a_bus_out, gen(u, 1'b0));
    ctl(5'h10, 5'h10);
  endtask : t_mail
  task automatic t_buf();
    logic [35:0] w;
    for (int i = 0; i < 2; i++) begin
      @(negedge ref_clk);
      odd_sense = 1'b1;
      ctl(5'h10, i ? 5'h10 : 5'h11);
      buf_read_load = 1'b1;
      w = 36'hF0F0F0F0F ^ i;
      @(negedge ref_clk);
      buf_read_load = 1'b0;
      ctl(5'h10, 5'h08);
      @(negedge ref_clk);
      cmp_word(port_b_bus_out, i ? w : gen(w, 1'b1));
    end
  endtask : t_buf
  task automatic print_verdict();
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    t_check();
    t_mail();
    t_buf();
    print_verdict();
  end
endmodule : tb_dppg_top
